// ===== port_pin_mode_pkg.sv
// Behaviour
// - Register 027H holds pin 1 mode in bits 3:2, pin 0 in 1:0, read/write.
// - Register 02AH holds other port pin 1 mode in 3:2, pin 0 in 1:0.
// - Input with mode 00 enables the pull-down resistor; default input setting.
// - Input with mode 10 enables the pull-up resistor.
// - Input with mode lower bit set is high impedance, no resistor.
// - Output with mode 00 drives push-pull high and low; default output setting.
// - Output with mode 01 drives low only, floats when high is output.
// - Output with mode 10 drives high only, floats when low is output.
// - Output with mode 11 disables both drivers, pin high impedance.
// - Pin 2 uses the same encodings and resets to pull-down and push-pull.
// - Direction bit 0 selects input encodings, 1 selects output encodings.
// - Reset clears every port control register to zero.
package port_pin_mode_pkg;

  // Pin counts of the two ports
  localparam int SECOND_PINS = 4;
  localparam int THIRD_PINS = 2;
  localparam int NUM_PINS = SECOND_PINS + THIRD_PINS;

  // APB geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 4;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_SECOND_CTRL_LOW = 10'h027;
  localparam logic [9:0] IDX_SECOND_CTRL_HIGH = 10'h028;
  localparam logic [9:0] IDX_THIRD_CTRL_LOW = 10'h02A;
  localparam logic [9:0] IDX_SECOND_DIR = 10'h030;
  localparam logic [9:0] IDX_THIRD_DIR = 10'h031;
  localparam logic [9:0] IDX_SECOND_DATA = 10'h032;
  localparam logic [9:0] IDX_THIRD_DATA = 10'h033;
  localparam logic [9:0] IDX_PAD_STATUS = 10'h034;

  // Values after reset
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] DIR_RESET = 4'h0;
  localparam logic [3:0] DATA_RESET = 4'h0;

  // Mode field encodings
  localparam logic [1:0] IN_PULL_DOWN = 2'h0;
  localparam logic [1:0] IN_PULL_UP = 2'h2;
  localparam int IN_HIZ_BIT = 0;
  localparam logic [1:0] OUT_PUSH_PULL = 2'h0;
  localparam logic [1:0] OUT_OPEN_LOW = 2'h1;
  localparam logic [1:0] OUT_OPEN_HIGH = 2'h2;
  localparam logic [1:0] OUT_HIZ = 2'h3;

  // Register select, one-hot
  typedef enum logic [8:0] {
    SEL_NONE = 9'h001,
    SEL_SECOND_CTRL_LOW = 9'h002,
    SEL_SECOND_CTRL_HIGH = 9'h004,
    SEL_THIRD_CTRL_LOW = 9'h008,
    SEL_SECOND_DIR = 9'h010,
    SEL_THIRD_DIR = 9'h020,
    SEL_SECOND_DATA = 9'h040,
    SEL_THIRD_DATA = 9'h080,
    SEL_PAD_STATUS = 9'h100
  } reg_sel_t;

endpackage : port_pin_mode_pkg

// ===== pin_sync.sv
module pin_sync
  import port_pin_mode_pkg::*;
#(
  parameter int WIDTH = NUM_PINS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q, meta_d;
  logic [WIDTH-1:0] sync_q, sync_d;

  // First stage feeds the second stage only
  always_comb begin
    meta_d = d;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q = sync_q;

endmodule : pin_sync

// ===== pin_pad_decode.sv
module pin_pad_decode
  import port_pin_mode_pkg::*;
(
  // Pin setting
  input wire logic [1:0] mode,
  input wire logic dir,
  input wire logic dout,
  // Pad controls
  output logic pull_up,
  output logic pull_down,
  output logic drive_high,
  output logic drive_low
);

  always_comb begin
    pull_up = 1'b0;
    pull_down = 1'b0;
    drive_high = 1'b0;
    drive_low = 1'b0;
    if (!dir) begin
      if (mode[IN_HIZ_BIT]) begin
        pull_up = 1'b0;
      end else if (mode == IN_PULL_UP) begin
        pull_up = 1'b1;
      end else begin
        pull_down = 1'b1;
      end
    end else begin
      case (mode)
        OUT_PUSH_PULL: begin
          drive_high = dout;
          drive_low = !dout;
        end
        OUT_OPEN_LOW: begin
          drive_low = !dout;
        end
        OUT_OPEN_HIGH: begin
          drive_high = dout;
        end
        OUT_HIZ: begin
          drive_high = 1'b0;
        end
        default: begin
          drive_high = 1'b0;
        end
      endcase
    end
  end

endmodule : pin_pad_decode

// ===== port_pin_mode_select.sv
module port_pin_mode_select
  import port_pin_mode_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins: second port in bits 3:0, third port in bits 5:4
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe,
  // Pad termination and driver controls
  output logic [NUM_PINS-1:0] pull_up_en,
  output logic [NUM_PINS-1:0] pull_down_en,
  output logic [NUM_PINS-1:0] drive_high_en,
  output logic [NUM_PINS-1:0] drive_low_en
);

  // Word decode shared by the read and write paths
  function automatic reg_sel_t decode_sel(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[ADDR_W-1:2])
        IDX_SECOND_CTRL_LOW: sel = SEL_SECOND_CTRL_LOW;
        IDX_SECOND_CTRL_HIGH: sel = SEL_SECOND_CTRL_HIGH;
        IDX_THIRD_CTRL_LOW: sel = SEL_THIRD_CTRL_LOW;
        IDX_SECOND_DIR: sel = SEL_SECOND_DIR;
        IDX_THIRD_DIR: sel = SEL_THIRD_DIR;
        IDX_SECOND_DATA: sel = SEL_SECOND_DATA;
        IDX_THIRD_DATA: sel = SEL_THIRD_DATA;
        IDX_PAD_STATUS: sel = SEL_PAD_STATUS;
        default: sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decode_sel

  // Pins seen through the synchroniser
  logic [NUM_PINS-1:0] pin_level;

  pin_sync #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pad_in),
    .q(pin_level)
  );

  // Software state
  logic [CTRL_W-1:0] second_ctrl_low_q, second_ctrl_low_d;
  logic [CTRL_W-1:0] second_ctrl_high_q, second_ctrl_high_d;
  logic [CTRL_W-1:0] third_ctrl_low_q, third_ctrl_low_d;
  logic [SECOND_PINS-1:0] second_dir_q, second_dir_d;
  logic [THIRD_PINS-1:0] third_dir_q, third_dir_d;
  logic [SECOND_PINS-1:0] second_data_q, second_data_d;
  logic [THIRD_PINS-1:0] third_data_q, third_data_d;

  // Bus answer state
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  // Pad output state
  logic [NUM_PINS-1:0] pull_up_q, pull_up_d;
  logic [NUM_PINS-1:0] pull_down_q, pull_down_d;
  logic [NUM_PINS-1:0] drive_high_q, drive_high_d;
  logic [NUM_PINS-1:0] drive_low_q, drive_low_d;
  logic [NUM_PINS-1:0] pad_oe_q, pad_oe_d;

  reg_sel_t sel;
  logic setup_phase;
  logic write_now;
  logic low_lane;

  always_comb begin
    sel = decode_sel(paddr);
    setup_phase = psel && !penable;
    // Answer is ready in the first access cycle, so this marks the commit
    write_now = psel && penable && pready_q && pwrite && !pslverr_q;
    low_lane = pstrb[0];
  end

  // Concatenated per-pin views
  logic [2*NUM_PINS-1:0] mode_all;
  logic [NUM_PINS-1:0] dir_all;
  logic [NUM_PINS-1:0] data_all;

  always_comb begin
    mode_all = {third_ctrl_low_q, second_ctrl_high_q, second_ctrl_low_q};
    dir_all = {third_dir_q, second_dir_q};
    data_all = {third_data_q, second_data_q};
  end

  // Per-pin decode of mode, direction and data
  logic [NUM_PINS-1:0] pu_w, pd_w, dh_w, dl_w;

  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      pin_pad_decode u_decode (
        .mode(mode_all[2*p +: 2]),
        .dir(dir_all[p]),
        .dout(data_all[p]),
        .pull_up(pu_w[p]),
        .pull_down(pd_w[p]),
        .drive_high(dh_w[p]),
        .drive_low(dl_w[p])
      );
    end
  endgenerate

  // Register writes; only the low byte lane carries defined bits
  always_comb begin
    second_ctrl_low_d = second_ctrl_low_q;
    second_ctrl_high_d = second_ctrl_high_q;
    third_ctrl_low_d = third_ctrl_low_q;
    second_dir_d = second_dir_q;
    third_dir_d = third_dir_q;
    second_data_d = second_data_q;
    third_data_d = third_data_q;
    if (write_now && low_lane) begin
      case (sel)
        SEL_SECOND_CTRL_LOW: begin
          second_ctrl_low_d = pwdata[CTRL_W-1:0];
        end
        SEL_SECOND_CTRL_HIGH: begin
          second_ctrl_high_d = pwdata[CTRL_W-1:0];
        end
        SEL_THIRD_CTRL_LOW: begin
          third_ctrl_low_d = pwdata[CTRL_W-1:0];
        end
        SEL_SECOND_DIR: begin
          second_dir_d = pwdata[SECOND_PINS-1:0];
        end
        SEL_THIRD_DIR: begin
          third_dir_d = pwdata[THIRD_PINS-1:0];
        end
        SEL_SECOND_DATA: begin
          second_data_d = pwdata[SECOND_PINS-1:0];
        end
        SEL_THIRD_DATA: begin
          third_data_d = pwdata[THIRD_PINS-1:0];
        end
        default: begin
          second_dir_d = second_dir_q;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_ctrl_low_q <= CTRL_RESET;
      second_ctrl_high_q <= CTRL_RESET;
      third_ctrl_low_q <= CTRL_RESET;
      second_dir_q <= DIR_RESET[SECOND_PINS-1:0];
      third_dir_q <= DIR_RESET[THIRD_PINS-1:0];
      second_data_q <= DATA_RESET[SECOND_PINS-1:0];
      third_data_q <= DATA_RESET[THIRD_PINS-1:0];
    end else begin
      second_ctrl_low_q <= second_ctrl_low_d;
      second_ctrl_high_q <= second_ctrl_high_d;
      third_ctrl_low_q <= third_ctrl_low_d;
      second_dir_q <= second_dir_d;
      third_dir_q <= third_dir_d;
      second_data_q <= second_data_d;
      third_data_q <= third_data_d;
    end
  end

  // Data reads show the latch for outputs and the pin level for inputs
  logic [NUM_PINS-1:0] data_view;
  logic [CTRL_W-1:0] pad_status;

  always_comb begin
    data_view = (dir_all & data_all) | (~dir_all & pin_level);
    // Status shows whether any pad has each drive or pull enable on right now
    pad_status = '0;
    pad_status[0] = |drive_high_q;
    pad_status[1] = |drive_low_q;
    pad_status[2] = |pull_up_q;
    pad_status[3] = |pull_down_q;
  end

  // Read data and answer, sampled in the setup phase so they leave flops
  always_comb begin
    prdata_d = '0;
    pready_d = setup_phase;
    pslverr_d = setup_phase && (sel == SEL_NONE);
    if (setup_phase && !pwrite) begin
      case (sel)
        SEL_SECOND_CTRL_LOW: begin
          prdata_d[CTRL_W-1:0] = second_ctrl_low_q;
        end
        SEL_SECOND_CTRL_HIGH: begin
          prdata_d[CTRL_W-1:0] = second_ctrl_high_q;
        end
        SEL_THIRD_CTRL_LOW: begin
          prdata_d[CTRL_W-1:0] = third_ctrl_low_q;
        end
        SEL_SECOND_DIR: begin
          prdata_d[SECOND_PINS-1:0] = second_dir_q;
        end
        SEL_THIRD_DIR: begin
          prdata_d[THIRD_PINS-1:0] = third_dir_q;
        end
        SEL_SECOND_DATA: begin
          prdata_d[SECOND_PINS-1:0] = data_view[SECOND_PINS-1:0];
        end
        SEL_THIRD_DATA: begin
          prdata_d[THIRD_PINS-1:0] = data_view[NUM_PINS-1:SECOND_PINS];
        end
        SEL_PAD_STATUS: begin
          prdata_d[CTRL_W-1:0] = pad_status;
        end
        default: begin
          prdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Pad controls are registered; one cycle after a write lands
  always_comb begin
    pull_up_d = pu_w;
    pull_down_d = pd_w;
    drive_high_d = dh_w;
    drive_low_d = dl_w;
    // Own flop so the pad enable is not a gate after the drive flops
    pad_oe_d = dh_w | dl_w;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_up_q <= '0;
      // Reset state is input with pull-down on every pin
      pull_down_q <= '1;
      drive_high_q <= '0;
      drive_low_q <= '0;
      pad_oe_q <= '0;
    end else begin
      pull_up_q <= pull_up_d;
      pull_down_q <= pull_down_d;
      drive_high_q <= drive_high_d;
      drive_low_q <= drive_low_d;
      pad_oe_q <= pad_oe_d;
    end
  end

  // Drive enables never overlap, so the pad level follows the high side
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pull_up_en = pull_up_q;
  assign pull_down_en = pull_down_q;
  assign drive_high_en = drive_high_q;
  assign drive_low_en = drive_low_q;
  assign pad_out = drive_high_q;
  assign pad_oe = pad_oe_q;

endmodule : port_pin_mode_select

// ===== port_pin_mode_select_sva.sv
module port_pin_mode_select_sva
  import port_pin_mode_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pads
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire logic [NUM_PINS-1:0] pull_up_en,
  input wire logic [NUM_PINS-1:0] pull_down_en,
  input wire logic [NUM_PINS-1:0] drive_high_en,
  input wire logic [NUM_PINS-1:0] drive_low_en
);
  logic [11:0] mode_q, mode_d;
  logic [5:0] dir_q, dir_d, dout_q, dout_d;
  logic [5:0] exp_pu, exp_pd, exp_dh, exp_dl;
  logic [3:0] exp_rd;
  logic wr, ctrl_hit, mapped;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  // Shadow of the writable state, used to predict pad controls
  always_comb begin
    mode_d = mode_q;
    dir_d = dir_q;
    dout_d = dout_q;
    ctrl_hit = paddr[1:0] == 2'h0;
    mapped = ctrl_hit;
    exp_rd = 4'h0;
    case (paddr[11:2])
      IDX_SECOND_CTRL_LOW: exp_rd = mode_q[3:0];
      IDX_SECOND_CTRL_HIGH: exp_rd = mode_q[7:4];
      IDX_THIRD_CTRL_LOW: exp_rd = mode_q[11:8];
      IDX_SECOND_DIR, IDX_THIRD_DIR, IDX_SECOND_DATA, IDX_THIRD_DATA,
      IDX_PAD_STATUS: ctrl_hit = 1'b0;
      default: begin
        ctrl_hit = 1'b0;
        mapped = 1'b0;
      end
    endcase
    if (wr && paddr[1:0] == 2'h0) begin
      case (paddr[11:2])
        IDX_SECOND_CTRL_LOW: mode_d[3:0] = pwdata[3:0];
        IDX_SECOND_CTRL_HIGH: mode_d[7:4] = pwdata[3:0];
        IDX_THIRD_CTRL_LOW: mode_d[11:8] = pwdata[3:0];
        IDX_SECOND_DIR: dir_d[3:0] = pwdata[3:0];
        IDX_THIRD_DIR: dir_d[5:4] = pwdata[1:0];
        IDX_SECOND_DATA: dout_d[3:0] = pwdata[3:0];
        IDX_THIRD_DATA: dout_d[5:4] = pwdata[1:0];
        default: ;
      endcase
    end
    for (int i = 0; i < 6; i++) begin
      exp_pd[i] = !dir_q[i] && mode_q[2*i+:2] == IN_PULL_DOWN;
      exp_pu[i] = !dir_q[i] && mode_q[2*i+:2] == IN_PULL_UP;
      exp_dh[i] = dir_q[i] && dout_q[i] && !mode_q[2*i];
      exp_dl[i] = dir_q[i] && !dout_q[i] && !mode_q[2*i+1];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= '0;
      dir_q <= '0;
      dout_q <= '0;
    end else begin
      mode_q <= mode_d;
      dir_q <= dir_d;
      dout_q <= dout_d;
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  chk_ready_pulse: assert property (setup_s |=> access_s ##1 !pready)
    else $error("pready not a single cycle after setup");
  chk_ctrl_read: assert property (setup_s ##0 (!pwrite && ctrl_hit) |=>
    prdata == {28'h0, $past(exp_rd)} && !pslverr)
    else $error("control register read mismatch");
  chk_unmapped_err: assert property (setup_s ##0 !mapped |=>
    pslverr && prdata == '0) else $error("unmapped access not refused");
  chk_pull_down_map: assert property (!$past(wr) |->
    pull_down_en == exp_pd) else $error("pull_down_en wrong");
  chk_pull_up_map: assert property (!$past(wr) |->
    pull_up_en == exp_pu) else $error("pull_up_en wrong");
  chk_high_drive: assert property (!$past(wr) |->
    drive_high_en == exp_dh) else $error("drive_high_en wrong");
  chk_low_drive: assert property (!$past(wr) |->
    drive_low_en == exp_dl) else $error("drive_low_en wrong");
  chk_oe_tracks: assert property (pad_oe == (drive_high_en | drive_low_en))
    else $error("pad_oe differs from drive enables");
  chk_no_overlap: assert property ((pull_up_en & pull_down_en) == '0 &&
    ((drive_high_en | drive_low_en) & (pull_up_en | pull_down_en)) == '0)
    else $error("pull and drive overlap");
endmodule : port_pin_mode_select_sva

bind port_pin_mode_select port_pin_mode_select_sva u_sva (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en), .drive_high_en(drive_high_en),
  .drive_low_en(drive_low_en)
);

// ===== pin_load.sv
module pin_load (
  // Clock
  input wire logic pclk,
  // Pad controls
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe,
  input wire logic [5:0] pull_up_en,
  input wire logic [5:0] pull_down_en,
  // Pin levels
  output logic [5:0] pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] last_q = '0;
  // A floating pin toggles so a stale level never reads as valid
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (pull_up_en[i]) begin
        pad_in[i] = 1'b1;
      end else if (pull_down_en[i]) begin
        pad_in[i] = 1'b0;
      end else begin
        pad_in[i] = ~last_q[i];
      end
    end
  end
  always @(posedge pclk) last_q <= pad_in;
endmodule : pin_load

// ===== port_pin_mode_select_tb.sv
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; $display("[FAIL] %s expected %h seen %h", nm, e, a); end end
module port_pin_mode_select_tb;
  import port_pin_mode_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  logic [5:0] pad_in, pad_out, pad_oe, pu, pd, dh, dl;
  logic [11:0] ca [3];
  int errors = 0;
  int samples_checked = 0;
  port_pin_mode_select u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pu),
    .pull_down_en(pd), .drive_high_en(dh), .drive_low_en(dl));
  pin_load u_load (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up_en(pu), .pull_down_en(pd), .pad_in(pad_in));
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic conclude();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      conclude();
    end else begin
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rd(logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHK("prdata", e, rdata)
  endtask : rd
  // Checks the pad controls one and a half cycles after the last write lands
  task automatic pads(logic [5:0] u, logic [5:0] p, logic [5:0] h, logic [5:0] l);
    @(negedge pclk);
    `CHK("pull_up_en", u, pu)
    `CHK("pull_down_en", p, pd)
    `CHK("drive_high_en", h, dh)
    `CHK("drive_low_en", l, dl)
    `CHK("pad_oe", h | l, pad_oe)
    `CHK("pad_out", h, pad_out & pad_oe)
    @(posedge pclk);
  endtask : pads
  task automatic set_all(logic [1:0] m);
    for (int r = 0; r < 3; r++) wr(ca[r], {28'h0, m, m});
  endtask : set_all
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    conclude();
  end
  initial begin
    ca = '{{IDX_SECOND_CTRL_LOW, 2'b00}, {IDX_SECOND_CTRL_HIGH, 2'b00},
      {IDX_THIRD_CTRL_LOW, 2'b00}};
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pads(6'h00, 6'h3F, 6'h00, 6'h00);
    for (int r = 0; r < 3; r++) rd(ca[r], 32'h0);
    for (int r = 0; r < 3; r++) begin
      wr(ca[r], 32'hFFFF_FFFF);
      rd(ca[r], 32'h0000_000F);
    end
    for (int m = 0; m < 4; m++) begin
      set_all(m[1:0]);
      pads(m == 2 ? 6'h3F : 6'h00, m == 0 ? 6'h3F : 6'h00, 6'h0, 6'h0);
      // Terminated inputs read back the level the resistor sets
      if (!m[0]) rd({IDX_SECOND_DATA, 2'b00}, m == 2 ? 32'hF : 32'h0);
    end
    wr({IDX_SECOND_DIR, 2'b00}, 32'hF);
    wr({IDX_THIRD_DIR, 2'b00}, 32'h3);
    wr({IDX_SECOND_DATA, 2'b00}, 32'h5);
    wr({IDX_THIRD_DATA, 2'b00}, 32'h1);
    for (int m = 0; m < 4; m++) begin
      set_all(m[1:0]);
      pads(6'h0, 6'h0, m[0] ? 6'h0 : 6'h15, m[1] ? 6'h0 : 6'h2A);
    end
    wr(ca[0], 32'h8);
    wr(ca[1], 32'h1);
    wr(ca[2], 32'h6);
    wr({IDX_SECOND_DIR, 2'b00}, 32'hC);
    wr({IDX_THIRD_DIR, 2'b00}, 32'h1);
    wr({IDX_SECOND_DATA, 2'b00}, 32'h8);
    pads(6'h02, 6'h01, 6'h18, 6'h04);
    rd({IDX_PAD_STATUS, 2'b00}, 32'hF);
    apb(1'b1, ca[0], 32'h0, 4'h0);
    rd(ca[0], 32'h8);
    apb(1'b1, {10'h3FF, 2'b00}, 32'hF, 4'hF);
    `CHK("pslverr", 1'b1, rerr)
    rd({10'h3FF, 2'b00}, 32'h0);
    `CHK("pslverr", 1'b1, rerr)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pads(6'h00, 6'h3F, 6'h00, 6'h00);
    rd(ca[1], 32'h0);
    rd({IDX_PAD_STATUS, 2'b00}, 32'h8);
    conclude();
  end
endmodule : port_pin_mode_select_tb
